/* bench/smbus_bus_model.sv */
// Far-side bus partner: open-drain lines with pull-ups and START/STOP/clock tasks
`timescale 1ns/100ps
`default_nettype none
module smbus_bus_model
(
  input wire logic clk_i,
  input wire logic swap_i,
  input wire logic lo_oe_i,
  input wire logic hi_oe_i,
  output logic pin_lo_o,
  output logic pin_hi_o
);
  logic sda_pull = 1'b0;
  logic scl_pull = 1'b0;
  // Wired-AND with pull-up: a released line reads high, never a stale value
  assign pin_lo_o = ~(lo_oe_i | (swap_i ? scl_pull : sda_pull));
  assign pin_hi_o = ~(hi_oe_i | (swap_i ? sda_pull : scl_pull));
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  // Data falls while clock high, clock follows after hold cycles
  task automatic start_cond(input int hold);
    @(posedge clk_i) sda_pull <= 1'b1;
    idle(hold);
    scl_pull <= 1'b1;
    idle(4);
  endtask : start_cond
  // Clock at 200 ns: four system clocks per half period, only inside frames
  task automatic clock_pulses(input int n);
    repeat (n)
    begin
      scl_pull <= 1'b0;
      idle(4);
      scl_pull <= 1'b1;
      idle(4);
    end
  endtask : clock_pulses
  task automatic set_lines(input logic sda_low, input logic scl_low);
    @(posedge clk_i);
    sda_pull <= sda_low;
    scl_pull <= scl_low;
    idle(8);
  endtask : set_lines
  // Clock released first, then data rises while clock high
  task automatic stop_cond();
    set_lines(1'b1, 1'b0);
    set_lines(1'b0, 1'b0);
  endtask : stop_cond
endmodule : smbus_bus_model
`default_nettype wire

/* bench/smbus_config_timing_ctrl_tb.sv */
// Testbench for the bus timing and pin control block
`timescale 1ns/100ps
`default_nettype none
module smbus_config_timing_ctrl_tb;
  import smbus_timing_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, swap = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, q;
  logic [3:0] sel = 4'h0, ovf = 4'h0;
  logic sda_drv = 1'b0, scl_drv = 1'b0, split = 1'b0;
  logic [31:0] dat_o;
  logic ack, lo_in, hi_in, lo_o, lo_oe, hi_o, hi_oe, r3, r3h, tick, en, inh, busy, seen, irq;
  int num_errors = 0, checked = 0;
  smbus_timing_ctrl smbus_timing_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pin_lo_i(lo_in), .pin_hi_i(hi_in), .pin_lo_o(lo_o),
    .pin_lo_oe_o(lo_oe), .pin_hi_o(hi_o), .pin_hi_oe_o(hi_oe), .sda_drive_low_i(sda_drv),
    .scl_drive_low_i(scl_drv), .timer0_ovf_i(ovf[0]), .timer1_ovf_i(ovf[1]),
    .timer2_hi_ovf_i(ovf[2]), .timer2_lo_ovf_i(ovf[3]), .timer3_split_i(split),
    .timer3_reload_o(r3), .timer3_hi_reload_o(r3h), .bitrate_tick_o(tick),
    .bus_enable_o(en), .slave_inhibit_o(inh), .bus_busy_o(busy), .start_seen_o(seen),
    .irq_o(irq));
  smbus_bus_model smbus_bus_model_i (.clk_i(clk_i), .swap_i(swap), .lo_oe_i(lo_oe),
    .hi_oe_i(hi_oe), .pin_lo_o(lo_in), .pin_hi_o(hi_in));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Classic cycle: request held until ack is sampled, then released for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, a, d, s};
    // No local limit: only the watchdog ends a wait that never gets an answer
    do
    begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb, we} <= 3'h0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, {24'h0, d}, 4'hF);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(q, exp);
  endtask : rd_chk
  task automatic wait_start(output logic hit);
    hit = 1'b0;
    repeat (24)
    begin
      @(posedge clk_i);
      #1 if (seen === 1'b1) hit = 1'b1;
    end
  endtask : wait_start
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(ADDR_CONFIG, 32'h0);
    rd_chk(ADDR_TIMING_PIN, 32'h0);
    rd_chk(ADDR_EVT_ENABLE, 32'h0);
    wr(ADDR_TIMING_PIN, 8'h83);
    rd_chk(ADDR_TIMING_PIN, 32'h83);
    wb(1'b1, ADDR_TIMING_PIN, 32'h0, 4'h0);
    rd_chk(ADDR_TIMING_PIN, 32'h83);
    wr(ADDR_CONFIG, 8'hFF);
    rd_chk(ADDR_CONFIG, 32'hDF);
    chk({en, inh}, 2'h3);
    wr(8'h00, 8'h55);
    rd_chk(8'h00, 32'h0);
  endtask : t_regs
  // Each selector code passes only its own overflow
  task automatic t_source();
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_CONFIG, 8'h80 | c[7:0]);
      for (int i = 0; i < 4; i++)
      begin
        @(posedge clk_i) ovf <= 4'h1 << i;
        @(posedge clk_i) ovf <= 4'h0;
        #1 chk(tick, i == c);
      end
    end
  endtask : t_source
  task automatic t_reload();
    // Pin order back to normal so the model and the design agree on the lines
    wr(ADDR_TIMING_PIN, 8'h00);
    wr(ADDR_CONFIG, 8'h88);
    for (int s = 0; s < 2; s++)
    begin
      split <= s[0];
      smbus_bus_model_i.idle(4);
      chk({r3, r3h}, s ? 2'h1 : 2'h2);
      smbus_bus_model_i.set_lines(1'b0, 1'b1);
      chk({r3, r3h}, 2'h0);
      smbus_bus_model_i.set_lines(1'b0, 1'b0);
    end
  endtask : t_reload
  // Holds just above each window and just below windows 01, 10 and 11, both pin orders
  task automatic t_start();
    logic hit;
    logic [3:0] need;
    for (int c = 0; c < 4; c++)
    begin
      need = c == 0 ? START_HOLD_00 : c == 1 ? START_HOLD_01 : c == 2 ? START_HOLD_10
        : START_HOLD_11;
      swap <= c[0];
      wr(ADDR_TIMING_PIN, {c[0], 5'h0, c[1:0]});
      smbus_bus_model_i.start_cond(need + 2);
      wait_start(hit);
      chk(hit, 1'b1);
      chk(busy, 1'b1);
      smbus_bus_model_i.clock_pulses(2);
      smbus_bus_model_i.stop_cond();
      chk(busy, 1'b0);
      if (c != 0)
      begin
        smbus_bus_model_i.start_cond(need - 2);
        wait_start(hit);
        chk(hit, 1'b0);
        smbus_bus_model_i.stop_cond();
      end
    end
  endtask : t_start
  // Event status, mask and clear; then free timeout on the eleventh source tick
  task automatic t_events_free();
    wr(ADDR_CONFIG, 8'h84);
    wr(ADDR_EVT_CLEAR, 8'h07);
    wr(ADDR_EVT_ENABLE, 8'h01);
    chk(irq, 1'b0);
    // Window code 11 is still set, so the hold must exceed eight clocks
    smbus_bus_model_i.start_cond(10);
    smbus_bus_model_i.idle(3);
    chk(irq, 1'b1);
    wr(ADDR_EVT_CLEAR, 8'h01);
    smbus_bus_model_i.idle(3);
    chk(irq, 1'b0);
    smbus_bus_model_i.set_lines(1'b0, 1'b1);
    smbus_bus_model_i.set_lines(1'b0, 1'b0);
    for (int i = 0; i < 11; i++)
    begin
      chk(busy, 1'b1);
      @(posedge clk_i) ovf <= 4'h1;
      @(posedge clk_i) ovf <= 4'h0;
      smbus_bus_model_i.idle(3);
    end
    chk(busy, 1'b0);
    rd_chk(ADDR_EVT_STATUS, 32'h4);
    chk(irq, 1'b0);
  endtask : t_events_free
  // Extended hold delays the data pull by the extra cycles
  task automatic t_hold();
    int n[2];
    // Normal pin order, so data drives the lower pin and clock the higher
    swap <= 1'b0;
    wr(ADDR_TIMING_PIN, 8'h00);
    for (int e = 0; e < 2; e++)
    begin
      wr(ADDR_CONFIG, e ? 8'h90 : 8'h80);
      @(posedge clk_i) sda_drv <= 1'b1;
      n[e] = 0;
      do
      begin
        @(posedge clk_i);
        #1 n[e]++;
      end while (lo_oe !== 1'b1 && n[e] < 40);
      chk(lo_o, 1'b0);
      @(posedge clk_i) sda_drv <= 1'b0;
      smbus_bus_model_i.idle(30);
    end
    chk(n[1] - n[0], SDA_HOLD_EXT_CYC - SDA_HOLD_NORMAL_CYC);
    // Clock drive reaches the higher pin two clocks after the request
    chk(hi_oe, 1'b0);
    @(posedge clk_i) scl_drv <= 1'b1;
    smbus_bus_model_i.idle(3);
    chk({hi_oe, hi_o, lo_oe}, 3'h4);
    @(posedge clk_i) scl_drv <= 1'b0;
    smbus_bus_model_i.idle(8);
  endtask : t_hold
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial
  begin
    #1000000;
    num_errors++;
    summarize();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_source();
    t_reload();
    t_start();
    t_events_free();
    t_hold();
    summarize();
  end
endmodule : smbus_config_timing_ctrl_tb
`default_nettype wire

/* rtl/line_if.sv */
// Interface: one synchronised bus line with its level and edge pulses
`timescale 1ns/100ps
`default_nettype none
interface line_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : line_if
`default_nettype wire

/* rtl/line_sync.sv */
// Module: three-stage synchroniser with agreement filter for one bus line
`timescale 1ns/100ps
`default_nettype none
module line_sync
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  line_if.src ln
);

  logic ff1;
  logic ff2;
  logic ff3;
  logic next_level;

  // Idle bus is pulled high, so all stages start high
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ff1 <= 1'b1;
      ff2 <= 1'b1;
      ff3 <= 1'b1;
    end
    else
    begin
      ff1 <= pin_i;
      ff2 <= ff1;
      ff3 <= ff2;
    end
  end

  // A change counts only once the second and third stages agree
  assign next_level = (ff2 == ff3) ? ff3 : ln.level;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ln.level <= 1'b1;
      ln.rise <= 1'b0;
      ln.fall <= 1'b0;
    end
    else
    begin
      ln.level <= next_level;
      ln.rise <= next_level & ~ln.level;
      ln.fall <= ~next_level & ln.level;
    end
  end

endmodule : line_sync
`default_nettype wire

/* rtl/smbus_timing_ctrl.sv */
// Module: bus configuration, timing and pin control with register slave and events
//
// Behaviour
// [R01] Extension bit lengthens data setup and hold
// [R02] Clock-low timeout reloads third timer while clock high
// [R03] Split timer: only upper byte held in reload
// [R04] Firmware sets 25 ms timeout, handler resets bus
// [R05] Bus free after clock, data high >10 periods
// [R06] Two-bit selector picks bit-rate overflow source
// [R07] Pin-order bit swaps data and clock crossbar pins
// [R08] START needs data fall, then clock fall later
// [R09] Window code 00 adds no extra hold
// [R10] Codes 01/10/11 need 2, 4, 8 clocks
// [R11] Busy set in transfer, cleared on STOP/free
// [R12] Software writes zeros to five reserved bits
`timescale 1ns/100ps
`default_nettype none
module smbus_timing_ctrl
  import smbus_timing_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Crossbar pins, open drain
  input wire logic pin_lo_i,
  input wire logic pin_hi_i,
  output logic pin_lo_o,
  output logic pin_lo_oe_o,
  output logic pin_hi_o,
  output logic pin_hi_oe_o,
  // Drive requests from the byte engine, same clock
  input wire logic sda_drive_low_i,
  input wire logic scl_drive_low_i,
  // Timer overflow pulses and third timer mode
  input wire logic timer0_ovf_i,
  input wire logic timer1_ovf_i,
  input wire logic timer2_hi_ovf_i,
  input wire logic timer2_lo_ovf_i,
  input wire logic timer3_split_i,
  output logic timer3_reload_o,
  output logic timer3_hi_reload_o,
  // To the rest of the unit
  output logic bitrate_tick_o,
  output logic bus_enable_o,
  output logic slave_inhibit_o,
  output logic bus_busy_o,
  output logic start_seen_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] bus_configuration;
  logic [7:0] bus_timing_pin_control;
  logic [EVT_WIDTH-1:0] evt_status;
  logic [EVT_WIDTH-1:0] evt_enable;
  logic [3:0] free_cnt;
  logic [3:0] hold_cnt;
  logic start_armed;
  logic [3:0] sh_cnt;
  logic sda_drive;
  logic scl_drive;

  line_if lo_line ();
  line_if hi_line ();

  line_sync u_sync_lo
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_lo_i),
    .ln(lo_line.src)
  );

  line_sync u_sync_hi
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_hi_i),
    .ln(hi_line.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Field decode and pin mapping

  wire swap = bus_timing_pin_control[TPC_SWAP_BIT];
  wire [1:0] win_code = bus_timing_pin_control[TPC_WIN_HI:TPC_WIN_LO];
  wire enable = bus_configuration[CFG_ENABLE_BIT];
  wire ext_hold = bus_configuration[CFG_SETUP_HOLD_EXTEND_EN_BIT];
  wire toe = bus_configuration[CFG_TOE_BIT];
  wire fte = bus_configuration[CFG_FTE_BIT];
  wire [1:0] src_sel = bus_configuration[CFG_SRC_HI:CFG_SRC_LO];

  // Data on the lower pin unless swapped
  wire sda_level = swap ? hi_line.level : lo_line.level; // see [R07]
  wire sda_rise = swap ? hi_line.rise : lo_line.rise;
  wire sda_fall = swap ? hi_line.fall : lo_line.fall;
  wire scl_level = swap ? lo_line.level : hi_line.level; // see [R07]
  wire scl_fall = swap ? lo_line.fall : hi_line.fall;
  wire next_lo_oe = swap ? scl_drive : sda_drive; // see [R07]
  wire next_hi_oe = swap ? sda_drive : scl_drive; // see [R07]

  ////////////////////////////////////////////////////////////////////////////
  // Bit-rate source and timers

  wire next_tick = (src_sel == SRC_TIMER0) ? timer0_ovf_i : // see [R06]
                   (src_sel == SRC_TIMER1) ? timer1_ovf_i :
                   (src_sel == SRC_TIMER2_HI) ? timer2_hi_ovf_i : timer2_lo_ovf_i;
  // Split mode keeps the lower byte free for other work
  wire next_reload = toe & scl_level & ~timer3_split_i; // see [R02]
  wire next_hi_reload = toe & scl_level & timer3_split_i; // see [R03]

  ////////////////////////////////////////////////////////////////////////////
  // Line condition detection

  wire both_high = scl_level & sda_level;
  wire free_evt = enable & fte & both_high & bitrate_tick_o
                  & (free_cnt == FREE_TICKS); // see [R05]
  wire [3:0] hold_need = (win_code == 2'h0) ? START_HOLD_00 : // see [R09]
                         (win_code == 2'h1) ? START_HOLD_01 : // see [R10]
                         (win_code == 2'h2) ? START_HOLD_10 : START_HOLD_11;
  wire start_evt = enable & start_armed & scl_fall & (hold_cnt >= hold_need); // see [R08]
  wire stop_evt = enable & sda_rise & scl_level;
  wire [EVT_WIDTH-1:0] evt_set = {free_evt, stop_evt, start_evt};

  // Free counter counts source ticks while both lines stay high
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !both_high || !fte)
      free_cnt <= 4'h0;
    else if (bitrate_tick_o && free_cnt != FREE_TICKS)
      free_cnt <= free_cnt + 4'h1; // see [R05]
  end

  // Arm on data falling with clock high, measure hold until clock falls
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable || scl_fall || sda_rise)
      start_armed <= 1'b0;
    else if (sda_fall && scl_level)
      start_armed <= 1'b1; // see [R08]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !start_armed)
      hold_cnt <= 4'h0;
    else if (hold_cnt != 4'hF)
      hold_cnt <= hold_cnt + 4'h1;
  end

  // Clearing takes priority over a new START only for STOP and free timeout
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable || stop_evt || free_evt)
      bus_busy_o <= 1'b0; // see [R11]
    else if (start_evt)
      bus_busy_o <= 1'b1; // see [R11]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data drive with setup and hold spacing

  wire [3:0] sh_target = ext_hold ? SDA_HOLD_EXT_CYC : SDA_HOLD_NORMAL_CYC; // see [R01]
  wire sh_done = (sh_cnt + 4'h1) >= sh_target;

  // A new data level waits the hold time before it reaches the pin
  always_ff @(posedge clk_i)
  begin
    if (rst_i || sda_drive_low_i == sda_drive)
      sh_cnt <= 4'h0;
    else if (!sh_done)
      sh_cnt <= sh_cnt + 4'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable)
      sda_drive <= 1'b0;
    else if (sda_drive_low_i != sda_drive && sh_done)
      sda_drive <= sda_drive_low_i; // see [R01]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !enable)
      scl_drive <= 1'b0;
    else
      scl_drive <= scl_drive_low_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flops

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_lo_o <= 1'b0;
      pin_hi_o <= 1'b0;
      pin_lo_oe_o <= 1'b0;
      pin_hi_oe_o <= 1'b0;
      bitrate_tick_o <= 1'b0;
      timer3_reload_o <= 1'b0;
      timer3_hi_reload_o <= 1'b0;
      start_seen_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      pin_lo_oe_o <= next_lo_oe;
      pin_hi_oe_o <= next_hi_oe;
      bitrate_tick_o <= next_tick;
      timer3_reload_o <= next_reload;
      timer3_hi_reload_o <= next_hi_reload;
      start_seen_o <= start_evt;
      irq_o <= |(evt_status & evt_enable);
    end
  end

  assign bus_enable_o = bus_configuration[CFG_ENABLE_BIT];
  assign slave_inhibit_o = bus_configuration[CFG_INHIBIT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_lane0 = req & wb_we_i & wb_sel_i[0];
  wire hit_tpc = wb_adr_i == ADDR_TIMING_PIN;
  wire hit_cfg = wb_adr_i == ADDR_CONFIG;
  wire hit_sts = wb_adr_i == ADDR_EVT_STATUS;
  wire hit_clr = wb_adr_i == ADDR_EVT_CLEAR;
  wire hit_ena = wb_adr_i == ADDR_EVT_ENABLE;
  wire [7:0] cfg_read = {bus_configuration[7:6], bus_busy_o, bus_configuration[4:0]};
  // Reserved timing bits read as zero; clear register reads zero
  wire [7:0] rd_byte = hit_tpc ? {swap, 5'h00, win_code} :
                       hit_cfg ? cfg_read :
                       hit_sts ? {5'h00, evt_status} :
                       hit_ena ? {5'h00, evt_enable} : 8'h00;
  wire [EVT_WIDTH-1:0] clr_mask = (wr_lane0 && hit_clr) ? wb_dat_i[EVT_WIDTH-1:0] : 3'h0;

  // One wait state: ack follows the request edge, unmapped reads give zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req;
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end

  // Reserved bits are not stored, so a stray write cannot upset them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_configuration <= CONFIG_RESET;
      bus_timing_pin_control <= TIMING_PIN_RESET;
      evt_enable <= EVT_ENABLE_RESET;
    end
    else if (wr_lane0)
    begin
      if (hit_cfg)
        bus_configuration <= {wb_dat_i[7:6], 1'b0, wb_dat_i[4:0]};
      if (hit_tpc)
        bus_timing_pin_control <= {wb_dat_i[7], 5'h00, wb_dat_i[1:0]};
      if (hit_ena)
        evt_enable <= wb_dat_i[EVT_WIDTH-1:0];
    end
  end

  // Sticky events: a set in the clearing cycle wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_status <= 3'h0;
    else
      evt_status <= (evt_status & ~clr_mask) | evt_set;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_hold_normal_wait: assert property ( // see [R01]
    (!ext_hold && sda_drive_low_i != sda_drive) |=> (sda_drive == $past(sda_drive_low_i))
      || $past(!enable) || $past(sda_drive_low_i) == $past(sda_drive, 2))
    else $error("normal data hold not one cycle");
  chk_hold_ext_wait: assert property ( // see [R01]
    ($changed(sda_drive) && $past(ext_hold) && $past(enable)) |->
      $past(sh_cnt) == SDA_HOLD_EXT_CYC - 4'h1)
    else $error("extended data hold count wrong");
  chk_reload_clock_high: assert property ( // see [R02]
    (toe && scl_level && !timer3_split_i) |=> timer3_reload_o && !timer3_hi_reload_o)
    else $error("timer reload missing while clock high");
  chk_split_upper_only: assert property ( // see [R03]
    (toe && timer3_split_i) |=> !timer3_reload_o && (timer3_hi_reload_o == $past(scl_level)))
    else $error("split timer reload wrong");
  chk_free_after_ten: assert property ( // see [R05]
    free_evt |-> fte && free_cnt == FREE_TICKS && both_high)
    else $error("free timeout before ten periods");
  chk_source_select: assert property ( // see [R06]
    (src_sel == SRC_TIMER2_LO) |=> bitrate_tick_o == $past(timer2_lo_ovf_i))
    else $error("bit-rate source select wrong");
  chk_pin_order_map: assert property ( // see [R07]
    ##1 pin_lo_oe_o == ($past(swap) ? $past(scl_drive) : $past(sda_drive)))
    else $error("pin order mapping wrong");
  chk_start_hold_window: assert property ( // see [R10]
    start_evt |-> hold_cnt >= hold_need && (win_code != 2'h3 || hold_cnt >= 4'h8))
    else $error("start taken inside hold window");
  chk_busy_stop_clear: assert property ( // see [R11]
    (stop_evt || free_evt) |=> !bus_busy_o)
    else $error("busy not cleared on stop or free");
  chk_irq_level: assert property (
    (|(evt_status & evt_enable)) |=> irq_o)
    else $error("interrupt not raised");

  cov_start_seen: cover property (start_evt ##[1:200] stop_evt);
  cov_free_timeout: cover property (free_evt);
  cov_swapped_start: cover property (swap && start_evt);
  cov_irq_raised: cover property ($rose(irq_o));

endmodule : smbus_timing_ctrl
`default_nettype wire

/* rtl/smbus_timing_pkg.sv */
// Package: register map, field layout, reset values and timing counts of the bus timing block
package smbus_timing_pkg;

  // Register byte addresses on the register bus
  localparam logic [7:0] ADDR_TIMING_PIN = 8'hAC;
  localparam logic [7:0] ADDR_CONFIG = 8'hB0;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'hB4;
  localparam logic [7:0] ADDR_EVT_CLEAR = 8'hB8;
  localparam logic [7:0] ADDR_EVT_ENABLE = 8'hBC;

  // Configuration register fields
  localparam int CFG_ENABLE_BIT = 7;
  localparam int CFG_INHIBIT_BIT = 6;
  localparam int CFG_BUSY_BIT = 5;
  localparam int CFG_SETUP_HOLD_EXTEND_EN_BIT = 4;
  localparam int CFG_TOE_BIT = 3;
  localparam int CFG_FTE_BIT = 2;
  localparam int CFG_SRC_HI = 1;
  localparam int CFG_SRC_LO = 0;

  // Timing and pin control register fields
  localparam int TPC_SWAP_BIT = 7;
  localparam int TPC_WIN_HI = 1;
  localparam int TPC_WIN_LO = 0;

  // Event bit positions in status, clear and enable registers
  localparam int EVT_START_BIT = 0;
  localparam int EVT_STOP_BIT = 1;
  localparam int EVT_FREE_BIT = 2;
  localparam int EVT_WIDTH = 3;

  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] TIMING_PIN_RESET = 8'h00;
  localparam logic [EVT_WIDTH-1:0] EVT_ENABLE_RESET = 3'h0;

  // Bit-rate clock source selector codes
  typedef enum logic [1:0] {
    SRC_TIMER0 = 2'h0,
    SRC_TIMER1 = 2'h1,
    SRC_TIMER2_HI = 2'h2,
    SRC_TIMER2_LO = 2'h3
  } bitrate_src_t;

  // Bus free when both lines stay high for more than this many source periods
  localparam logic [3:0] FREE_TICKS = 4'hA;

  // Data must fall more than this many system clocks before clock falls, per window code
  localparam logic [3:0] START_HOLD_00 = 4'h0;
  localparam logic [3:0] START_HOLD_01 = 4'h2;
  localparam logic [3:0] START_HOLD_10 = 4'h4;
  localparam logic [3:0] START_HOLD_11 = 4'h8;

  // System clocks a data line change waits, normal and extended
  localparam logic [3:0] SDA_HOLD_NORMAL_CYC = 4'h1;
  localparam logic [3:0] SDA_HOLD_EXT_CYC = 4'hC;

endpackage : smbus_timing_pkg
